// ==== verilog/asbs_board_ctrl.sv ====
// motherboard status concentration, board select and router table logic
`timescale 1ns/1ps
`include "asbs_regs.svh"
module asbs_board_ctrl
  import asbs_pkg::*;
#(
  parameter logic [2:0] MB_ROW = 3'h0,  // this motherboard's row position
  parameter logic [2:0] MB_COL = 3'h0   // this motherboard's column position
) (
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic         instr_valid,
  input  wire logic [31:0]  instr_word,
  input  wire logic [63:0]  board_some,
  input  wire logic [63:0]  board_store_done,
  input  wire logic [63:0]  board_comparand,
  input  wire logic [63:0]  board_mem_error,
  input  wire logic [191:0] board_done,
  input  wire logic [63:0]  board_hold_ack,
  input  wire logic [7:0]   conn_rd_addr,
  output logic      [4:0]   status_lines,
  output logic      [7:0]   row_enable,
  output logic      [7:0]   col_enable,
  output logic      [63:0]  chip_enable,
  output logic              router_sync,
  output logic              fwd_valid,
  output logic      [31:0]  fwd_word,
  output logic      [15:0]  conn_rd_data
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  asbs_state_type s;                       // present state
  asbs_state_type next_s;                  // next state
  logic [15:0]    conn_tbl [0:255];        // router connection table
  logic [3:0]     op;                      // opcode of synchronised word
  logic [3:0]     brd;                     // board argument
  logic [7:0]     mask;                    // {high, low} mask nibbles
  logic [2:0]     sel_idx;                 // row or column index
  logic           is_mb;                   // motherboard instruction
  logic           tbl_we;                  // router table write strobe
  logic [2:0]     dn_any;                  // done bit k seen on any board

  // true for opcodes executed on the motherboard itself
  function automatic logic mb_op(input logic [3:0] code);
    mb_op = (code == `ASBS_OP_RTR_WRITE) || (code == `ASBS_OP_RTR_START) ||
            (code == `ASBS_OP_CHIP_SEL)  || (code == `ASBS_OP_STAT_SEL);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // field decode of the synchronised instruction
  assign op      = s.iw_s2[`ASBS_OP_HI:`ASBS_OP_LO];
  assign brd     = s.iw_s2[`ASBS_BRD_HI:`ASBS_BRD_LO];
  assign mask    = {s.iw_s2[`ASBS_MSKH_HI:`ASBS_MSKH_LO], s.iw_s2[`ASBS_MSKL_HI:`ASBS_MSKL_LO]};
  assign sel_idx = {brd[3], brd[1:0]};
  assign is_mb   = mb_op(op);
  assign tbl_we  = s.iv_s2 && (op == `ASBS_OP_RTR_WRITE);

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb begin
    next_s = s;
    // two-flop synchronisers on every controller and board input, bus taken without handshake
    next_s.iv_s1   = instr_valid;
    next_s.iv_s2   = s.iv_s1;
    next_s.iw_s1   = instr_word;
    next_s.iw_s2   = s.iw_s1;
    next_s.some_s1 = board_some;
    next_s.some_s2 = s.some_s1;
    next_s.bsd_s1  = board_store_done;
    next_s.bsd_s2  = s.bsd_s1;
    next_s.cmp_s1  = board_comparand;
    next_s.cmp_s2  = s.cmp_s1;
    next_s.err_s1  = board_mem_error;
    next_s.err_s2  = s.err_s1;
    next_s.hld_s1  = board_hold_ack;
    next_s.hld_s2  = s.hld_s1;
    next_s.dn_s1   = board_done;
    next_s.dn_s2   = s.dn_s1;
    // pulses last one cycle
    next_s.sync      = 1'b0;
    next_s.fwd_valid = 1'b0;
    if (s.iv_s2) begin
      case (op)
        // router start: one sync pulse to every chip
        `ASBS_OP_RTR_START: begin
          next_s.sync = 1'b1;
        end
        // chip select: row flag picks the register, index must be ours
        `ASBS_OP_CHIP_SEL: begin
          if (brd[2]) begin
            if (sel_idx == MB_ROW) begin
              next_s.row_mask = mask;
            end
          end else begin
            if (sel_idx == MB_COL) begin
              next_s.col_mask = mask;
            end
          end
        end
        // status group select for the shared lines
        `ASBS_OP_STAT_SEL: begin
          next_s.grp = s.iw_s2[`ASBS_GRP_BIT] ? ASBS_GRP_DONE : ASBS_GRP_EVENTS;
        end
        // router write handled by the table process
        `ASBS_OP_RTR_WRITE: begin
          next_s.fwd_valid = 1'b0;
        end
        // everything else goes to the chips untouched
        default: begin
          next_s.fwd_valid = 1'b1;
          next_s.fwd_word  = s.iw_s2;
        end
      endcase
    end
    // status concentration: any board asserting sets the line
    next_s.status[`ASBS_ST_HOLD] = |s.hld_s2;
    next_s.status[`ASBS_ST_SOME] = |s.some_s2;
    case (s.grp)
      ASBS_GRP_DONE: begin
        for (int k = 0; k < 3; k++) begin
          next_s.status[`ASBS_ST_SHARED + k] = 1'b0;
          for (int b = 0; b < `ASBS_BOARDS; b++) begin
            next_s.status[`ASBS_ST_SHARED + k] =
              next_s.status[`ASBS_ST_SHARED + k] | s.dn_s2[3 * b + k];
          end
        end
      end
      default: begin
        next_s.status[2] = |s.err_s2;
        next_s.status[3] = |s.bsd_s2;
        next_s.status[4] = |s.cmp_s2;
      end
    endcase
    // table read port for the router switch
    next_s.conn_rd = conn_tbl[conn_rd_addr];
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s          <= '0;
      s.grp      <= ASBS_GRP_EVENTS;
      s.row_mask <= `ASBS_MASK_RST;
      s.col_mask <= `ASBS_MASK_RST;
    end else begin
      s <= next_s;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // router connection table, one entry per address, no reset needed
  always_ff @(posedge sys_clk) begin
    if (tbl_we) begin
      conn_tbl[s.iw_s2[`ASBS_RADDR_HI:`ASBS_RADDR_LO]] <=
        s.iw_s2[`ASBS_RDATA_HI:`ASBS_RDATA_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // per-board enable: a chip acts only when its row and column are on
  for (genvar g = 0; g < `ASBS_BOARDS; g++) begin : g_en
    assign chip_enable[g] = s.row_mask[g / `ASBS_SIDE] & s.col_mask[g % `ASBS_SIDE];
  end

  ////////////////////////////////////////////////////////////////////////////
  // any-board OR of each done bit, kept apart from the status path for checking
  for (genvar k = 0; k < 3; k++) begin : g_dn
    assign dn_any[k] = |(s.dn_s2 & {`ASBS_BOARDS{3'b001 << k}});
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign status_lines = s.status;
  assign row_enable   = s.row_mask;
  assign col_enable   = s.col_mask;
  assign router_sync  = s.sync;
  assign fwd_valid    = s.fwd_valid;
  assign fwd_word     = s.fwd_word;
  assign conn_rd_data = s.conn_rd;

  ////////////////////////////////////////////////////////////////////////////
  // assertions
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  a_hold_or_line: assert property (
    status_lines[0] == $past(|s.hld_s2))
    else $error("hold line not OR of boards");

  a_some_or_line: assert property (
    status_lines[1] == $past(|s.some_s2))
    else $error("some line not OR of boards");

  a_event_group: assert property (
    ($past(s.grp) == ASBS_GRP_EVENTS) |->
      status_lines[4:2] == {$past(|s.cmp_s2), $past(|s.bsd_s2), $past(|s.err_s2)})
    else $error("event group lines wrong");

  a_done_group: assert property (
    ($past(s.grp) == ASBS_GRP_DONE) |-> status_lines[4:2] == $past(dn_any))
    else $error("done group lines wrong");

  a_row_load: assert property (
    (s.iv_s2 && op == `ASBS_OP_CHIP_SEL && brd[2] && sel_idx == MB_ROW)
      |=> row_enable == $past(mask))
    else $error("row mask not loaded");

  a_col_hold: assert property (
    (s.iv_s2 && op == `ASBS_OP_CHIP_SEL && brd[2]) |=> $stable(col_enable))
    else $error("column mask changed on row select");

  a_sync_cause: assert property (
    router_sync |-> $past(s.iv_s2 && op == `ASBS_OP_RTR_START))
    else $error("sync without router start");

  a_fwd_word: assert property (
    (s.iv_s2 && !is_mb) |=> fwd_valid && fwd_word == $past(s.iw_s2))
    else $error("instruction not forwarded");

  a_group_sel: assert property (
    (s.iv_s2 && op == `ASBS_OP_STAT_SEL && s.iw_s2[0]) |=> ##1 s.grp == ASBS_GRP_DONE)
    else $error("group select not taken");

  a_chip_gate: assert property (
    chip_enable[9] == (row_enable[1] & col_enable[1]))
    else $error("chip enable gating wrong");

  // column load on our own column index
  a_col_load: assert property (
    (s.iv_s2 && op == `ASBS_OP_CHIP_SEL && !brd[2] && sel_idx == MB_COL)
      |=> col_enable == $past(mask))
    else $error("column mask not loaded");

  // a column select leaves the row register alone
  a_row_hold: assert property (
    (s.iv_s2 && op == `ASBS_OP_CHIP_SEL && !brd[2]) |=> $stable(row_enable))
    else $error("row mask changed on column select");

  // a row select for another row is ignored
  a_row_foreign: assert property (
    (s.iv_s2 && op == `ASBS_OP_CHIP_SEL && brd[2] && sel_idx != MB_ROW)
      |=> $stable(row_enable))
    else $error("row mask loaded for foreign row");

  // a column select for another column is ignored
  a_col_foreign: assert property (
    (s.iv_s2 && op == `ASBS_OP_CHIP_SEL && !brd[2] && sel_idx != MB_COL)
      |=> $stable(col_enable))
    else $error("column mask loaded for foreign column");

  // every router start gives a sync pulse
  a_sync_start: assert property (
    (s.iv_s2 && op == `ASBS_OP_RTR_START) |=> router_sync)
    else $error("router start gave no sync");

  // a forward only follows a non-motherboard instruction
  a_fwd_cause: assert property (
    fwd_valid |-> $past(s.iv_s2 && !is_mb))
    else $error("forward without element instruction");

  // motherboard instructions stay on the motherboard
  a_mb_local: assert property (
    (s.iv_s2 && is_mb) |=> !fwd_valid)
    else $error("motherboard instruction forwarded");

  // the group changes only on a status select
  a_group_hold: assert property (
    !(s.iv_s2 && op == `ASBS_OP_STAT_SEL) |=> $stable(s.grp))
    else $error("group changed without select");

  // a router write lands in the addressed entry
  a_tbl_write: assert property (
    tbl_we |=> conn_tbl[$past(s.iw_s2[`ASBS_RADDR_HI:`ASBS_RADDR_LO])] ==
      $past(s.iw_s2[`ASBS_RDATA_HI:`ASBS_RDATA_LO]))
    else $error("router table entry not written");

  // first and last boards follow their row and column bits
  a_chip_first: assert property (
    chip_enable[0] == (row_enable[0] & col_enable[0]))
    else $error("first chip enable gating wrong");

  a_chip_last: assert property (
    chip_enable[63] == (row_enable[7] & col_enable[7]))
    else $error("last chip enable gating wrong");

endmodule

// ==== verilog/asbs_regs.svh ====
// constants for the board status and board select logic
`ifndef ASBS_REGS_SVH
`define ASBS_REGS_SVH
// instruction word fields
`define ASBS_OP_HI       31
`define ASBS_OP_LO       28
`define ASBS_BRD_HI      27
`define ASBS_BRD_LO      24
`define ASBS_BRD_ROW     26
`define ASBS_MSKL_HI     23
`define ASBS_MSKL_LO     20
`define ASBS_MSKH_HI     19
`define ASBS_MSKH_LO     16
`define ASBS_RADDR_HI    23
`define ASBS_RADDR_LO    16
`define ASBS_RDATA_HI    15
`define ASBS_RDATA_LO    0
`define ASBS_GRP_BIT     0
// motherboard opcodes
`define ASBS_OP_RTR_WRITE 4'h1
`define ASBS_OP_RTR_START 4'h2
`define ASBS_OP_CHIP_SEL  4'h3
`define ASBS_OP_STAT_SEL  4'h4
// sizes
`define ASBS_SIDE         8
`define ASBS_BOARDS       64
`define ASBS_CONN_REGS    256
`define ASBS_CONN_W       16
`define ASBS_STAT_LINES   5
// reset values
`define ASBS_MASK_RST     8'hFF
// status line positions
`define ASBS_ST_HOLD      0
`define ASBS_ST_SOME      1
`define ASBS_ST_SHARED    2
`endif

// ==== verilog/asbs_pkg.sv ====
// types for the board status and board select logic
package asbs_pkg;
  // which group drives the three shared status lines
  typedef enum logic {
    ASBS_GRP_EVENTS,
    ASBS_GRP_DONE
  } asbs_group_type;

  // register state of the block except the router connection table
  typedef struct packed {
    logic           iv_s1;     // instruction valid, first stage
    logic           iv_s2;     // instruction valid, second stage
    logic [31:0]    iw_s1;     // instruction word, first stage
    logic [31:0]    iw_s2;     // instruction word, second stage
    logic [63:0]    some_s1;   // per-board some/none
    logic [63:0]    some_s2;
    logic [63:0]    bsd_s1;    // per-board backing store done
    logic [63:0]    bsd_s2;
    logic [63:0]    cmp_s1;    // per-board node comparand
    logic [63:0]    cmp_s2;
    logic [63:0]    err_s1;    // per-board memory test error
    logic [63:0]    err_s2;
    logic [63:0]    hld_s1;    // per-board hold acknowledge
    logic [63:0]    hld_s2;
    logic [191:0]   dn_s1;     // per-board done bits, three per board
    logic [191:0]   dn_s2;
    asbs_group_type grp;       // selected shared group
    logic [4:0]     status;    // lines returned to the controller
    logic [7:0]     row_mask;  // row enable register
    logic [7:0]     col_mask;  // column enable register
    logic           sync;      // router start pulse
    logic           fwd_valid; // forwarded instruction valid
    logic [31:0]    fwd_word;  // forwarded instruction word
    logic [15:0]    conn_rd;   // router table read data
  } asbs_state_type;
endpackage

// ==== verification/asbs_ctrl_model.sv ====
// array controller model: one-way broadcaster of instruction words
`timescale 1ns/1ps
module asbs_ctrl_model (
  input  wire logic        sys_clk,
  output logic             instr_valid,
  output logic      [31:0] instr_word
);
  // bus idle at time zero
  initial begin
    instr_valid = 1'b0;
    instr_word  = 32'h0000_0000;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // one instruction: word settles, one valid cycle, word held, then scrambled
  task automatic issue(input logic [31:0] w);
    @(negedge sys_clk);
    instr_word = w;
    repeat (2) @(negedge sys_clk);
    instr_valid = 1'b1;
    @(negedge sys_clk);
    instr_valid = 1'b0;
    repeat (3) @(negedge sys_clk);
    instr_word = ~w;
  endtask
endmodule

// ==== verification/tb_top.sv ====
// testbench for the board status and board select logic
`timescale 1ns/1ps
module tb_top;
  import asbs_pkg::*;
  logic         sys_clk;              // system clock
  logic         rst_n;                // reset, active low
  logic         instr_valid;          // from controller model
  logic [31:0]  instr_word;
  logic [63:0]  b_some, b_bsd, b_cmp, b_err, b_hld;  // per-board event pins
  logic [191:0] b_done;               // three done bits per board
  logic [7:0]   rd_addr;              // router table read address
  logic [4:0]   status_lines;
  logic [7:0]   row_enable, col_enable;
  logic [63:0]  chip_enable;
  logic         router_sync, fwd_valid;
  logic [31:0]  fwd_word, last_fwd;
  logic [15:0]  conn_rd_data;
  int           n_mismatch = 0, n_checks = 0, n_sync = 0, n_fwd = 0;
  // clock at 100 MHz
  initial sys_clk = 1'b0;
  always #5 sys_clk = ~sys_clk;
  asbs_ctrl_model u_ctrl (.sys_clk(sys_clk), .instr_valid(instr_valid), .instr_word(instr_word));
  asbs_board_ctrl #(.MB_ROW(3'h1), .MB_COL(3'h2)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .instr_valid(instr_valid), .instr_word(instr_word),
    .board_some(b_some), .board_store_done(b_bsd), .board_comparand(b_cmp),
    .board_mem_error(b_err), .board_done(b_done), .board_hold_ack(b_hld),
    .conn_rd_addr(rd_addr), .status_lines(status_lines), .row_enable(row_enable),
    .col_enable(col_enable), .chip_enable(chip_enable), .router_sync(router_sync),
    .fwd_valid(fwd_valid), .fwd_word(fwd_word), .conn_rd_data(conn_rd_data));
  ////////////////////////////////////////////////////////////////////////////////
  // count pulse cycles and remember the last forwarded word
  always @(negedge sys_clk) begin
    if (router_sync === 1'b1) n_sync++;
    if (fwd_valid === 1'b1) begin
      n_fwd++;
      last_fwd = fwd_word;
    end
  end
  // compare and report
  task automatic check(input string nm, input logic [191:0] seen, input logic [191:0] exp);
    n_checks++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // reset for ten cycles and check the reset image
  task automatic t_reset();
    @(negedge sys_clk);
    rst_n = 1'b0;
    repeat (10) @(negedge sys_clk);
    check("row_rst", row_enable, 8'hFF);
    check("col_rst", col_enable, 8'hFF);
    check("chip_rst", chip_enable, 64'hFFFF_FFFF_FFFF_FFFF);
    check("stat_rst", status_lines, 5'h00);
    rst_n = 1'b1;
    repeat (2) @(negedge sys_clk);
  endtask
  // each event source on a different board reaches its own line
  task automatic t_events();
    for (int k = 0; k < 5; k++) begin
      {b_hld, b_some, b_err, b_bsd, b_cmp} = '0;
      case (k)
        0: b_hld[k*13] = 1'b1;
        1: b_some[k*13] = 1'b1;
        2: b_err[k*13] = 1'b1;
        3: b_bsd[k*13] = 1'b1;
        default: b_cmp[k*13] = 1'b1;
      endcase
      repeat (4) @(negedge sys_clk);
      check("status_ev", status_lines, 5'h01 << k);
    end
    b_cmp = '0;
  endtask
  // done group selected, then events group restored
  task automatic t_done();
    b_err[63] = 1'b1;
    u_ctrl.issue(32'h4000_0001);
    for (int j = 0; j < 3; j++) begin
      b_done = '0;
      b_done[3*63+j] = 1'b1;
      repeat (4) @(negedge sys_clk);
      check("status_dn", status_lines, {3'h1 << j, 2'b00});
    end
    u_ctrl.issue(32'h4000_0000);
    repeat (2) @(negedge sys_clk);
    check("status_back", status_lines, 5'h04);
    b_err = '0;
    b_done = '0;
  endtask
  // row and column loads, foreign indices ignored
  task automatic t_select();
    u_ctrl.issue(32'h35A5_0000);
    u_ctrl.issue(32'h3236_0000);
    u_ctrl.issue(32'h3399_0000);
    u_ctrl.issue(32'h3499_0000);
    check("row_en", row_enable, 8'h5A);
    check("col_en", col_enable, 8'h63);
    for (int g = 0; g < 64; g++)
      check("chip_en", chip_enable[g], 8'h5A >> (g / 8) & 8'h63 >> (g % 8) & 1);
  endtask
  // router table writes at addresses 07 and FF, then a sync pulse
  task automatic t_router();
    int f0;
    f0 = n_fwd;
    u_ctrl.issue(32'h1007_BEEF);
    u_ctrl.issue(32'h10FF_1234);
    rd_addr = 8'h07;
    repeat (2) @(negedge sys_clk);
    check("tbl07", conn_rd_data, 16'hBEEF);
    rd_addr = 8'hFF;
    repeat (2) @(negedge sys_clk);
    check("tblFF", conn_rd_data, 16'h1234);
    check("no_fwd", n_fwd - f0, 0);
    f0 = n_sync;
    u_ctrl.issue(32'h2000_0000);
    check("sync", n_sync - f0, 1);
  endtask
  // element instruction forwarded unaltered, word held afterwards
  task automatic t_forward();
    int f0;
    f0 = n_fwd;
    u_ctrl.issue(32'h7123_4567);
    check("fwd_cnt", n_fwd - f0, 1);
    check("fwd_word", last_fwd, 32'h7123_4567);
    check("fwd_hold", fwd_word, 32'h7123_4567);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    rst_n   = 1'b0;
    {b_some, b_bsd, b_cmp, b_err, b_hld} = '0;
    b_done  = '0;
    rd_addr = 8'h00;
    t_reset();
    t_events();
    t_done();
    t_select();
    t_reset();
    t_router();
    t_forward();
    summarize();
  end
  // watchdog
  initial begin
    #50000;
    n_mismatch++;
    summarize();
  end
endmodule
